// ---- eptfd_top.sv ----
// Two timer/event counters with pin filter and frequency divider.
// Assumes pins are asynchronous and software uses the register port.
// How it works
// - Mode bits 01 select event counting
// - Event mode counts pin edges, no prescaler
// - Edge select low rising, high falling
// - Overflow raises request, reloads preload, continues
// - Event counting continues powered down; wakes device
// - Mode bits 11 select pulse width measurement
// - Pulse clocks: prescaled system; timer 1 sub or system/4
// - Run enable only arms pulse measurement
// - Edge low: start falling, stop rising, clear run
// - Edge high: start rising, stop falling, clear run
// - Other modes never clear run themselves
// - Hold residual count, ignore pin until rearmed
// - Pulse mode reacts to transitions, not levels
// - Divider source is timer 0 or 1 option
// - Divider output toggles on each selected overflow
// - Divider reaches pin only when option selects
// - Port data bit gates divider, low when zero
// - Port direction input suppresses divider output
// - Pull-high stays on while pin counts
// - One filter option for both timer input pins
// - Mode bits 10 select timer mode
// - Stopped preload write loads counter at once
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module eptfd_top #(
    parameter int CNT0_W = 8, // Timer 0 width
    parameter int CNT1_W = 16, // Timer 1 width
    parameter int PSC_STAGES = 7, // Prescaler stages
    parameter int FILT_CYC = 4 // Filter stable cycles
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [1:0] tmr_pin_in,
    input wire logic sub_clk_in,
    input wire logic power_down_in,
    input wire logic pa3_pin_in,
    output logic pa3_pin_out,
    output logic pa3_oe_out,
    output logic [1:0] pullup_out,
    output logic filter_en_out,
    output logic [1:0] irq_out,
    output logic wake_out
);
    // Refuse sizes the logic cannot serve
    if (CNT0_W < 2 || CNT0_W > 8 || CNT1_W < 9 || CNT1_W > 16 ||
        PSC_STAGES < 7 || FILT_CYC < 1 || FILT_CYC > 7) begin : g_chk
        $error("eptfd_top: unsupported parameter values");
    end

    // Configuration and port registers
    logic [7:0] pdata_reg, pdir_reg, opt_reg, pull_reg;
    // Synchroniser stages
    logic [1:0] pin_s1_reg, pin_s2_reg;
    logic sub_s1_reg, sub_s2_reg, sub_prev_reg;
    logic pa3_s1_reg, pa3_s2_reg;
    // Clock dividers
    logic [PSC_STAGES-1:0] psc_reg;
    logic [1:0] div4_reg;
    // Per-timer state
    logic [7:0] ctrl_reg [2];
    logic [15:0] pre_reg [2];
    logic [15:0] cnt_reg [2];
    eptfd_pkg::eptfd_phase_e phase_reg [2];
    logic [1:0] filt_reg, filt_prev_reg;
    logic [2:0] fcnt_reg [2];
    // Per-timer decode
    logic [1:0] tick_w, inc_w, full_w, ovf_w, hw_stop_w;
    logic [1:0] start_w, end_w, act_w, wr_ctrl_w, load_w;
    logic [15:0] pre_next_w [2];
    logic pfd_reg;
    logic [7:0] rdata_next;

    // Two-stage synchronisers on every pin input
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_s1_reg <= 2'h0;
            pin_s2_reg <= 2'h0;
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            pa3_s1_reg <= 1'b0;
            pa3_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= tmr_pin_in;
            pin_s2_reg <= pin_s1_reg;
            sub_s1_reg <= sub_clk_in;
            sub_s2_reg <= sub_s1_reg;
            pa3_s1_reg <= pa3_pin_in;
            pa3_s2_reg <= pa3_s1_reg;
        end
    end

    // Timer 0 prescaler and timer 1 clock sources
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            psc_reg <= '0;
            div4_reg <= 2'h0;
            sub_prev_reg <= 1'b0;
        end else begin
            psc_reg <= psc_reg + 1'b1;
            div4_reg <= div4_reg + 2'h1;
            sub_prev_reg <= sub_s2_reg;
        end
    end

    // Prescale mask from rate bits: divide by two to the rate
    eptfd_pkg::eptfd_ctrl_s ctl0, ctl1;
    assign ctl0 = eptfd_pkg::eptfd_ctrl_s'(ctrl_reg[0]);
    assign ctl1 = eptfd_pkg::eptfd_ctrl_s'(ctrl_reg[1]);
    wire [PSC_STAGES-1:0] psc_mask =
        PSC_STAGES'((32'd1 << ctl0.rate) - 32'd1);
    wire psc_tick = (psc_reg & psc_mask) == psc_mask;
    wire div4_tick = div4_reg == eptfd_pkg::DIV4_LAST;
    wire sub_tick = sub_s2_reg & ~sub_prev_reg;
    assign tick_w[0] = psc_tick;
    assign tick_w[1] = ctl1.clk_sel ? sub_tick : div4_tick;

    // One counter per timer
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam int W = (i == 0) ? CNT0_W : CNT1_W;
        localparam logic [15:0] MAXV = 16'((32'd1 << W) - 32'd1);
        localparam logic [3:0] A_CT = i ? eptfd_pkg::A_CTRL1
                                        : eptfd_pkg::A_CTRL0;
        localparam logic [3:0] A_LO = i ? eptfd_pkg::A_TMR1L
                                        : eptfd_pkg::A_TIMER0_INPUT_PIN;
        eptfd_pkg::eptfd_ctrl_s ctl;
        assign ctl = eptfd_pkg::eptfd_ctrl_s'(ctrl_reg[i]);
        // Edge detection on filtered samples
        wire rise = filt_reg[i] & ~filt_prev_reg[i];
        wire fall = ~filt_reg[i] & filt_prev_reg[i];
        wire is_evt = ctl.mode == eptfd_pkg::MODE_EVENT;
        wire is_tmr = ctl.mode == eptfd_pkg::MODE_TIMER;
        wire is_pls = ctl.mode == eptfd_pkg::MODE_PULSE;
        wire meas = phase_reg[i] == eptfd_pkg::PH_MEAS;
        assign act_w[i] = ctl.edge_sel ? fall : rise;
        assign start_w[i] = ctl.edge_sel ? rise : fall;
        assign end_w[i] = ctl.edge_sel ? fall : rise;
        // Count enable per mode; event mode bypasses prescaler
        assign inc_w[i] = is_tmr ? (ctl.run & tick_w[i])
            : is_evt ? (ctl.run & act_w[i])
            : is_pls ? (meas & tick_w[i]) : 1'b0;
        assign full_w[i] = cnt_reg[i] == MAXV;
        assign ovf_w[i] = inc_w[i] & full_w[i];
        assign hw_stop_w[i] = is_pls & meas & end_w[i];
        assign wr_ctrl_w[i] = wr_in & (addr_in == A_CT);
        wire wr_lo = wr_in & (addr_in == A_LO);
        wire wr_hi = (i == 1) & wr_in &
            (addr_in == eptfd_pkg::A_TMR1H);
        assign pre_next_w[i] = {wr_hi ? wdata_in : pre_reg[i][15:8],
                                wr_lo ? wdata_in : pre_reg[i][7:0]};
        assign load_w[i] = (wr_lo | wr_hi) & ~ctl.run;

        // Noise filter: level must hold before it is accepted
        always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                filt_reg[i] <= 1'b0;
                filt_prev_reg[i] <= 1'b0;
                fcnt_reg[i] <= 3'h0;
            end else begin
                filt_prev_reg[i] <= filt_reg[i];
                if (!opt_reg[eptfd_pkg::OPT_FILT]) begin
                    filt_reg[i] <= pin_s2_reg[i];
                    fcnt_reg[i] <= 3'h0;
                end else if (pin_s2_reg[i] == filt_reg[i]) begin
                    fcnt_reg[i] <= 3'h0;
                end else if (fcnt_reg[i] == 3'(FILT_CYC - 1)) begin
                    filt_reg[i] <= pin_s2_reg[i];
                    fcnt_reg[i] <= 3'h0;
                end else begin
                    fcnt_reg[i] <= fcnt_reg[i] + 3'h1;
                end
            end
        end

        // Control: software write wins over the hardware clear
        always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                ctrl_reg[i] <= eptfd_pkg::CTRL_RST;
            end else if (wr_ctrl_w[i]) begin
                ctrl_reg[i] <= wdata_in;
            end else if (hw_stop_w[i]) begin
                ctrl_reg[i][eptfd_pkg::RUN_BIT] <= 1'b0;
            end
        end

        // Measurement phase: armed by run, started by an edge
        always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                phase_reg[i] <= eptfd_pkg::PH_IDLE;
            end else begin
                unique case (phase_reg[i])
                    eptfd_pkg::PH_IDLE: begin
                        // Armed only; counting waits for the edge
                        if (is_pls && ctl.run && start_w[i]) begin
                            phase_reg[i] <= eptfd_pkg::PH_MEAS;
                        end
                    end
                    eptfd_pkg::PH_MEAS: begin
                        // Return edge, mode change or software stop
                        if (!is_pls || !ctl.run || end_w[i]) begin
                            phase_reg[i] <= eptfd_pkg::PH_IDLE;
                        end
                    end
                endcase
            end
        end

        // Preload and counter
        always_ff @(posedge sys_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                pre_reg[i] <= eptfd_pkg::PRE_RST;
                cnt_reg[i] <= eptfd_pkg::PRE_RST;
            end else begin
                pre_reg[i] <= pre_next_w[i];
                if (load_w[i]) begin
                    cnt_reg[i] <= pre_next_w[i];
                end else if (ovf_w[i]) begin
                    cnt_reg[i] <= pre_reg[i];
                end else if (inc_w[i]) begin
                    cnt_reg[i] <= cnt_reg[i] + 16'h0001;
                end
            end
        end
    end

    // Port, option and pull-high registers
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pdata_reg <= eptfd_pkg::PDATA_RST;
            pdir_reg <= eptfd_pkg::PDIR_RST;
            opt_reg <= eptfd_pkg::OPT_RST;
            pull_reg <= eptfd_pkg::PULL_RST;
        end else if (wr_in) begin
            if (addr_in == eptfd_pkg::A_PDATA) pdata_reg <= wdata_in;
            if (addr_in == eptfd_pkg::A_PDIR) pdir_reg <= wdata_in;
            if (addr_in == eptfd_pkg::A_OPT) opt_reg <= wdata_in;
            if (addr_in == eptfd_pkg::A_PULL) pull_reg <= wdata_in;
        end
    end

    // Divider source and shared pin selection
    wire pfd_src = opt_reg[eptfd_pkg::OPT_PSRC] ? ovf_w[1]
                                                 : ovf_w[0];
    wire pfd_sel = opt_reg[eptfd_pkg::OPT_PFD];
    wire pa3_data = pdata_reg[eptfd_pkg::PA3_BIT];
    wire pa3_dir_in = pdir_reg[eptfd_pkg::PA3_BIT];
    wire pa3_oe_next = ~pa3_dir_in;
    wire pa3_out_next = pfd_sel ? (pa3_data & pfd_reg)
                                : pa3_data;

    // Divider toggle and registered pin drivers
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pfd_reg <= 1'b0;
            pa3_pin_out <= 1'b0;
            pa3_oe_out <= 1'b0;
        end else begin
            if (pfd_src) pfd_reg <= ~pfd_reg;
            pa3_pin_out <= pa3_out_next;
            pa3_oe_out <= pa3_oe_next;
        end
    end

    // Read mux; unmapped reads return zero
    wire [7:0] stat_w = {5'h00,
        phase_reg[1] == eptfd_pkg::PH_MEAS,
        phase_reg[0] == eptfd_pkg::PH_MEAS, pa3_s2_reg};
    assign rdata_next =
        (addr_in == eptfd_pkg::A_CTRL0) ? ctrl_reg[0] :
        (addr_in == eptfd_pkg::A_TIMER0_INPUT_PIN) ? cnt_reg[0][7:0] :
        (addr_in == eptfd_pkg::A_CTRL1) ? ctrl_reg[1] :
        (addr_in == eptfd_pkg::A_TMR1L) ? cnt_reg[1][7:0] :
        (addr_in == eptfd_pkg::A_TMR1H) ? cnt_reg[1][15:8] :
        (addr_in == eptfd_pkg::A_PDATA) ? pdata_reg :
        (addr_in == eptfd_pkg::A_PDIR) ? pdir_reg :
        (addr_in == eptfd_pkg::A_OPT) ? opt_reg :
        (addr_in == eptfd_pkg::A_STAT) ? stat_w :
        (addr_in == eptfd_pkg::A_PULL) ? pull_reg : 8'h00;

    // Outputs to bus, interrupt controller and pads
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
            irq_out <= 2'h0;
            wake_out <= 1'b0;
            pullup_out <= 2'h0;
            filter_en_out <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rdata_next : 8'h00;
            irq_out <= ovf_w;
            wake_out <= power_down_in & (|ovf_w);
            pullup_out <= pull_reg[1:0];
            filter_en_out <= opt_reg[eptfd_pkg::OPT_FILT];
        end
    end

    // Checks on timer 0, the divider and the shared pin
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_pulse_start;
        ctl0.mode == eptfd_pkg::MODE_PULSE && ctl0.run && !wr_ctrl_w[0] &&
        phase_reg[0] == eptfd_pkg::PH_IDLE && start_w[0];
    endsequence

    AST_EVT_COUNT: assert property (
        ctl0.mode == eptfd_pkg::MODE_EVENT && ctl0.run && act_w[0]
        && !full_w[0] && !load_w[0]
        |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
        else $error("event edge did not count");
    AST_OVF_RELOAD: assert property (
        ovf_w[0] && !load_w[0]
        |=> cnt_reg[0] == $past(pre_reg[0]) && irq_out[0])
        else $error("overflow did not reload and request");
    AST_WAKE: assert property (
        power_down_in && ovf_w[0] |=> wake_out)
        else $error("overflow in power down did not wake");
    AST_ARMED_IDLE: assert property (
        ctl0.mode == eptfd_pkg::MODE_PULSE && ctl0.run &&
        phase_reg[0] == eptfd_pkg::PH_IDLE && !start_w[0] &&
        !load_w[0] |=> $stable(cnt_reg[0]))
        else $error("armed counter moved without edge");
    AST_PULSE_RUN: assert property (
        s_pulse_start ##1 (!wr_ctrl_w[0] && !end_w[0]) [*2]
        |-> phase_reg[0] == eptfd_pkg::PH_MEAS)
        else $error("measurement did not start on edge");
    AST_PULSE_STOP: assert property (
        hw_stop_w[0] && !wr_ctrl_w[0]
        |=> !ctl0.run ##1 phase_reg[0] == eptfd_pkg::PH_IDLE)
        else $error("pulse end did not clear run");
    AST_NO_SELF_CLR: assert property (
        ctl0.mode != eptfd_pkg::MODE_PULSE && ctl0.run &&
        !wr_ctrl_w[0] |=> ctl0.run)
        else $error("run cleared without software");
    AST_PRE_STOP: assert property (
        load_w[0] |=> cnt_reg[0] == pre_reg[0])
        else $error("stopped preload not copied to counter");
    AST_PFD_TOGGLE: assert property (
        pfd_src |=> pfd_reg != $past(pfd_reg))
        else $error("divider did not toggle on overflow");
    AST_PFD_PIN: assert property (
        pfd_sel && !pa3_data |=> !pa3_pin_out)
        else $error("divider pin not low with data zero");
    AST_DIR_IN: assert property (
        pa3_dir_in |=> !pa3_oe_out)
        else $error("pin driven while set as input");
endmodule : eptfd_top

// ---- eptfd_pkg.sv ----
// Shared constants and types of the timer/event counter block.
// Assumes an 8-bit register port and one 40 MHz system clock.
package eptfd_pkg;
    // Register indices on the 4-bit address port
    localparam logic [3:0] A_CTRL0 = 4'h0; // Timer 0 control
    localparam logic [3:0] A_TIMER0_INPUT_PIN = 4'h1; // W: preload, R: count
    localparam logic [3:0] A_CTRL1 = 4'h2; // Timer 1 control
    localparam logic [3:0] A_TMR1L = 4'h3; // Timer 1 low byte
    localparam logic [3:0] A_TMR1H = 4'h4; // Timer 1 high byte
    localparam logic [3:0] A_PDATA = 4'h5; // Port A output data
    localparam logic [3:0] A_PDIR = 4'h6; // Port A direction
    localparam logic [3:0] A_OPT = 4'h7; // Configuration options
    localparam logic [3:0] A_STAT = 4'h8; // Status, read only
    localparam logic [3:0] A_PULL = 4'h9; // Timer pin pull-highs
    // Field positions
    localparam int PA3_BIT = 3; // Port A line three
    localparam int RUN_BIT = 4; // Run enable in control
    localparam int OPT_FILT = 0; // Noise filter enable
    localparam int OPT_PSRC = 1; // Divider source: 1 = timer 1
    localparam int OPT_PFD = 2; // Divider owns the shared pin
    // Operating modes in control bits 7:6
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] PRE_RST = 16'h0000;
    localparam logic [7:0] PDATA_RST = 8'h00;
    localparam logic [7:0] PDIR_RST = 8'hFF; // All lines input
    localparam logic [7:0] OPT_RST = 8'h01; // Filter on
    localparam logic [7:0] PULL_RST = 8'h00;
    // Timer 1 internal divider last state (divide by four)
    localparam logic [1:0] DIV4_LAST = 2'h3;
    // Control register layout
    typedef struct packed {
        logic [1:0] mode; // Operating mode select
        logic clk_sel; // Timer 1: 1 = sub clock
        logic run; // Run enable
        logic edge_sel; // Active edge select
        logic [2:0] rate; // Timer 0 prescale rate
    } eptfd_ctrl_s;
    // Pulse measurement phase
    typedef enum logic {PH_IDLE, PH_MEAS} eptfd_phase_e;
endpackage : eptfd_pkg

// ---- eptfd_pulse_src.sv ----
// Model of the external event or pulse source on one timer pin.
// Assumes the system clock is given so edges land after a clock edge.
`timescale 1ns/1ps
module eptfd_pulse_src (
    input wire logic clk_in,
    output logic pin_out
);
    // Pin rests low until told otherwise
    initial begin
        pin_out = 1'b0;
    end
    // Drive a static level just after a clock edge
    task automatic set_level(input logic v);
        @(posedge clk_in);
        pin_out <= v;
    endtask : set_level
    // One pulse of w cycles away from the present resting level
    task automatic pulse(input int w);
        logic idle;
        idle = pin_out;
        set_level(~idle);
        repeat (w - 1) @(posedge clk_in);
        set_level(idle);
    endtask : pulse
endmodule : eptfd_pulse_src

// ---- test_event_pulse_timer_with_freq_divider.sv ----
// Self-checking bench for the timer/event counter block.
// Assumes filter off during counting tests so pin latency is short.
`timescale 1ns/1ps
module test_event_pulse_timer_with_freq_divider;
    typedef struct {logic [7:0] e; int tol;} eptfd_note_s; // Read note
    logic clk = 1'b0; // System clock
    logic nrst = 1'b0; // Active low reset
    logic [3:0] addr = 4'h0; // Register index
    logic [7:0] wdata = 8'h00; // Write data
    logic wr_s = 1'b0; // Write strobe
    logic rd_s = 1'b0; // Read strobe
    logic pdn = 1'b0; // Power down level
    logic [7:0] rdata; // Read data
    logic [1:0] pins, pull, irq; // Pins, pull-highs, requests
    logic pa3_out, pa3_oe, filt, wake, rd_d; // Port and status outputs
    eptfd_note_s notes[$]; // Expected read values, oldest first
    int bad_count = 0, n_checks = 0, irq0_cnt = 0, wake_cnt = 0, tog = 0;
    int irq1_cnt = 0, sub_div = 0; // Timer 1 requests, sub clock phase
    logic sub_clk = 1'b0, pa3_in = 1'b0, pa3_prev = 1'b0; // Sub clock, pin
    int s;
    logic [7:0] v;
    // Design under test and the two pin sources
    eptfd_top dut_u (.sys_clk_in(clk), .nrst_in(nrst), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
        .tmr_pin_in(pins), .sub_clk_in(sub_clk), .power_down_in(pdn),
        .pa3_pin_in(pa3_in), .pa3_pin_out(pa3_out), .pa3_oe_out(pa3_oe),
        .pullup_out(pull), .filter_en_out(filt), .irq_out(irq),
        .wake_out(wake));
    eptfd_pulse_src src0 (.clk_in(clk), .pin_out(pins[0]));
    eptfd_pulse_src src1 (.clk_in(clk), .pin_out(pins[1]));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Count requests, wake pulses, pin changes; sub clock of eight cycles
    always @(posedge clk) begin
        rd_d <= rd_s;
        sub_div <= (sub_div + 1) % 8;
        sub_clk <= sub_div >= 4;
        if (irq[0] === 1'b1) irq0_cnt++;
        if (irq[1] === 1'b1) irq1_cnt++;
        if (wake === 1'b1) wake_cnt++;
        if (pa3_out !== pa3_prev) tog++;
        pa3_prev <= pa3_out;
    end
    // Read data stands one cycle after the strobe: compare mid-cycle
    always @(negedge clk) begin
        if (rd_d === 1'b1) chk_byte(notes.pop_front(), rdata);
    end
    // Compare a read byte against its note, within the tolerance
    task automatic chk_byte(input eptfd_note_s n, input logic [7:0] seen);
        int d;
        d = int'(seen) - int'(n.e);
        n_checks++;
        if ((^seen === 1'bx) || d > n.tol || d < -n.tol) begin
            bad_count++;
            $display("CHECK FAILED rdata exp %0h seen %0h", n.e, seen);
        end
    endtask : chk_byte
    // Compare a single output bit
    task automatic chk_bit(input string nm, input logic e, input logic seen);
        n_checks++;
        if (seen !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %b seen %b", nm, e, seen);
        end
    endtask : chk_bit
    // Register write: one cycle strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    // Register read: note the expectation, then strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input int t);
        notes.push_back('{e, t});
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // Print counts and verdict, then stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end
    // Main sequence
    initial begin
        s = $urandom(32'h2F1A36FB);
        cyc(12);
        nrst <= 1'b1;
        rd(eptfd_pkg::A_CTRL0, 8'h00, 0);
        rd(eptfd_pkg::A_PDIR, 8'hFF, 0);
        rd(eptfd_pkg::A_OPT, 8'h01, 0);
        rd(4'hC, 8'h00, 0); // Unmapped reads zero
        chk_bit("filter_en", 1'b1, filt);
        wr(eptfd_pkg::A_OPT, 8'h00);
        cyc(3);
        chk_bit("filter_off", 1'b0, filt);
        // Shared pin level shows in status bit 0 after synchronising
        pa3_in <= 1'($urandom);
        cyc(3);
        rd(eptfd_pkg::A_STAT, {7'h00, pa3_in}, 0);
        pa3_in <= ~pa3_in;
        cyc(3);
        rd(eptfd_pkg::A_STAT, {7'h00, pa3_in}, 0);
        wr(eptfd_pkg::A_PULL, 8'h03);
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(eptfd_pkg::A_TIMER0_INPUT_PIN, v);
            rd(eptfd_pkg::A_TIMER0_INPUT_PIN, v, 0);
        end
        // Event counting: three rising edges from FC reach FF
        wr(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'hFC);
        wr(eptfd_pkg::A_CTRL0, 8'h50);
        chk_bit("pull", 1'b1, &pull);
        repeat (3) begin
            src0.pulse(8);
            cyc(8);
        end
        rd(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'hFF, 0);
        // Falling edge selected: a rise must not count
        wr(eptfd_pkg::A_CTRL0, 8'h58);
        src0.set_level(1'b1);
        cyc(10);
        rd(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'hFF, 0);
        pdn <= 1'b1;
        src0.set_level(1'b0);
        cyc(10);
        pdn <= 1'b0;
        rd(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'hFC, 0);
        chk_bit("irq0", 1'b1, irq0_cnt == 1);
        chk_bit("wake", 1'b1, wake_cnt == 1);
        rd(eptfd_pkg::A_CTRL0, 8'h58, 0);
        // Pulse width, both edges, rate 0 then rate 1 (half count)
        for (int e = 0; e < 2; e++) begin
            wr(eptfd_pkg::A_CTRL0, 8'h00);
            wr(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'h00);
            src0.set_level(e == 0 ? 1'b0 : 1'b1); // Static active level
            cyc(8);
            wr(eptfd_pkg::A_CTRL0, 8'(8'hD0 | (e << 3) | e));
            cyc(20);
            src0.set_level(e == 0 ? 1'b1 : 1'b0); // Back to idle
            cyc(10);
            rd(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'h00, 0);
            src0.pulse(40);
            cyc(10);
            rd(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'(40 >> e), 3);
            rd(eptfd_pkg::A_CTRL0, 8'(8'hC0 | (e << 3) | e), 0);
            src0.pulse(30);
            cyc(10);
            rd(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'(40 >> e), 3);
        end
        // Timer 1 pulse width on system clock over four
        src1.set_level(1'b1);
        wr(eptfd_pkg::A_TMR1L, 8'h00);
        wr(eptfd_pkg::A_TMR1H, 8'h00);
        wr(eptfd_pkg::A_CTRL1, 8'hD0);
        cyc(8);
        src1.pulse(80);
        cyc(10);
        rd(eptfd_pkg::A_TMR1L, 8'd20, 2);
        rd(eptfd_pkg::A_TMR1H, 8'h00, 0);
        // Same on the sub clock: one rising edge every eight cycles
        wr(eptfd_pkg::A_TMR1L, 8'h00);
        wr(eptfd_pkg::A_TMR1H, 8'h00);
        wr(eptfd_pkg::A_CTRL1, 8'hF0);
        cyc(8);
        src1.pulse(80);
        cyc(10);
        rd(eptfd_pkg::A_TMR1L, 8'd10, 2);
        // Divider from timer 0 on the shared pin
        wr(eptfd_pkg::A_CTRL0, 8'h00);
        wr(eptfd_pkg::A_OPT, 8'h04);
        wr(eptfd_pkg::A_PDIR, 8'hF7);
        wr(eptfd_pkg::A_PDATA, 8'h08);
        wr(eptfd_pkg::A_TIMER0_INPUT_PIN, 8'hFE);
        wr(eptfd_pkg::A_CTRL0, 8'h90);
        s = tog;
        cyc(20);
        chk_bit("pfd_run", 1'b1, tog - s >= 3);
        chk_bit("pa3_oe", 1'b1, pa3_oe);
        wr(eptfd_pkg::A_PDATA, 8'h00);
        cyc(4);
        s = tog;
        cyc(20);
        chk_bit("pfd_gate", 1'b1, tog == s && pa3_out === 1'b0);
        wr(eptfd_pkg::A_PDIR, 8'hFF);
        cyc(3);
        chk_bit("pa3_oe_in", 1'b0, pa3_oe);
        wr(eptfd_pkg::A_PDIR, 8'hF7);
        wr(eptfd_pkg::A_PDATA, 8'h08);
        wr(eptfd_pkg::A_OPT, 8'h00);
        cyc(4);
        s = tog;
        cyc(20);
        chk_bit("pa3_io", 1'b1, tog == s && pa3_out === 1'b1);
        // Source timer 1: stopped gives nothing, running toggles
        wr(eptfd_pkg::A_OPT, 8'h06);
        wr(eptfd_pkg::A_CTRL1, 8'h80);
        cyc(4);
        s = tog;
        cyc(20);
        chk_bit("src_t1_idle", 1'b1, tog == s);
        wr(eptfd_pkg::A_TMR1L, 8'hFF);
        wr(eptfd_pkg::A_TMR1H, 8'hFF);
        wr(eptfd_pkg::A_CTRL1, 8'h90);
        s = tog;
        cyc(30);
        chk_bit("src_t1_run", 1'b1, tog - s >= 3);
        chk_bit("irq1", 1'b1, irq1_cnt >= 3);
        chk_bit("wake_idle", 1'b1, wake_cnt == 1);
        cyc(4);
        end_sim();
    end
endmodule : test_event_pulse_timer_with_freq_divider
